/* File: rtl/ierb_pkg.sv */
// constants and types for the indirect extended register access block
package ierb_pkg;
   localparam int          DATA_W     = 16;
   localparam int          REG_ADDR_W = 5;
   localparam int          FUNC_MSB   = 15;
   localparam int          FUNC_LSB   = 14;
   localparam int          SPACE_MSB  = 4;
   localparam int          SPACE_LSB  = 0;

   localparam logic [4:0]  REG_CTRL      = 5'h0d;
   localparam logic [4:0]  REG_ADDR_DATA = 5'h0e;

   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_MASK  = 16'hc01f;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP  = 16'h0001;

   localparam logic [4:0]  SPC_MAIN  = 5'h1f;
   localparam logic [4:0]  SPC_PMA   = 5'h01;
   localparam logic [4:0]  SPC_VND3  = 5'h03;
   localparam logic [4:0]  SPC_VND7  = 5'h07;

   typedef enum logic [1:0] {
      FN_ADDR   = 2'h0,
      FN_DATA   = 2'h1,
      FN_INC_RW = 2'h2,
      FN_INC_WR = 2'h3
   } ierb_func_t;

   typedef enum logic [1:0] {
      SEL_ZERO = 2'h0,
      SEL_HOLD = 2'h1,
      SEL_MEM  = 2'h2
   } ierb_rsel_t;
endpackage

/* File: rtl/ierb_ext_mem.sv */
// storage for the four extended register spaces, registered read data
module ierb_ext_mem
   import ierb_pkg::*;
#(
   parameter int W  = 16,
   parameter int AW = 8
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // access
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [AW+1:0] idx,
   input  wire logic [W-1:0]  wdata,
   output logic      [W-1:0]  rdata
);
   if (AW < 1 || AW > 14 || W < 1)
   begin : g_chk
      $error("ierb_ext_mem parameters out of range");
   end

   logic [W-1:0] mem_ff [2**(AW+2)];
   logic [W-1:0] rdata_ff;
   logic [W-1:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (rd_en)
      begin
         nxt_rdata = mem_ff[idx];
      end
   end

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem_ff[idx] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
endmodule

/* File: rtl/ierb_indirect_access.sv */
// control and address/data register pair giving indirect access to extended spaces
module ierb_indirect_access
   import ierb_pkg::*;
#(
   parameter int EXT_AW = 8
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // register port
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_we,
   input  wire logic                  reg_re,
   output logic      [DATA_W-1:0]     reg_rdata
);
   // storage depth per space is 2**EXT_AW words, two more index bits pick the space
   if (EXT_AW < 1 || EXT_AW > 14)
   begin : g_chk
      $error("EXT_AW must lie in 1..14");
   end

   // the control mask and the address step are sixteen bits wide
   if (DATA_W != 16)
   begin : g_chk_width
      $error("DATA_W must be 16");
   end

   // both directly addressed registers need a five-bit index
   if (REG_ADDR_W != 5)
   begin : g_chk_index
      $error("REG_ADDR_W must be 5");
   end

   // function and space fields must fit the control word without overlap
   if (FUNC_MSB != FUNC_LSB + 1 || FUNC_MSB >= DATA_W || SPACE_MSB - SPACE_LSB != 4
       || SPACE_MSB >= FUNC_LSB)
   begin : g_chk_fields
      $error("control field positions do not fit");
   end

   // a zero step would turn the incrementing functions into plain data access
   if (ADDR_STEP == '0)
   begin : g_chk_step
      $error("ADDR_STEP must not be zero");
   end

   // storage slot of each supported space
   localparam logic [1:0] SLOT_MAIN = 2'h0;
   localparam logic [1:0] SLOT_PMA  = 2'h1;
   localparam logic [1:0] SLOT_VND3 = 2'h2;
   localparam logic [1:0] SLOT_VND7 = 2'h3;

   logic [DATA_W-1:0] ctrl_ff;
   logic [DATA_W-1:0] nxt_ctrl;
   logic [DATA_W-1:0] addr_ff;
   logic [DATA_W-1:0] nxt_addr;
   logic [DATA_W-1:0] hold_ff;
   logic [DATA_W-1:0] nxt_hold;
   ierb_rsel_t        rsel_ff;
   ierb_rsel_t        nxt_rsel;

   ierb_func_t        func;
   logic [4:0]        space;
   logic              space_ok;
   logic [1:0]        space_idx;
   logic              hit_ad;
   logic              in_range;
   logic              wr_ad;
   logic              rd_ad;
   logic              data_fn;
   logic              mem_we;
   logic              mem_re;
   logic              step_wr;
   logic              step_rd;
   logic              step;
   logic [DATA_W-1:0] mem_rdata;
   logic [EXT_AW+1:0] mem_idx;

   // space decode: four supported codes, everything else is refused
   always_comb
   begin
      func      = ierb_func_t'(ctrl_ff[FUNC_MSB:FUNC_LSB]);
      space     = ctrl_ff[SPACE_MSB:SPACE_LSB];
      space_ok  = 1'b1;
      space_idx = SLOT_MAIN;
      unique case (space)
         SPC_MAIN: space_idx = SLOT_MAIN;
         SPC_PMA:  space_idx = SLOT_PMA;
         SPC_VND3: space_idx = SLOT_VND3;
         SPC_VND7: space_idx = SLOT_VND7;
         default:  space_ok  = 1'b0;
      endcase
   end

   // access decode for the address/data register
   always_comb
   begin
      hit_ad   = (reg_addr == REG_ADDR_DATA);
      // addresses past the storage depth are dropped, not aliased
      in_range = ((addr_ff >> EXT_AW) == '0);
      wr_ad    = reg_we && hit_ad && space_ok;
      rd_ad    = reg_re && hit_ad && space_ok;
      data_fn  = (func != FN_ADDR);
      mem_we   = wr_ad && data_fn && in_range;
      mem_re   = rd_ad && data_fn && in_range;
      // write side steps for 10 and 11, read side only for 10
      step_wr  = wr_ad && (func == FN_INC_RW || func == FN_INC_WR);
      step_rd  = rd_ad && (func == FN_INC_RW);
      step     = step_wr || step_rd;
      mem_idx  = {space_idx, addr_ff[EXT_AW-1:0]};
   end

   // control group
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (reg_we && reg_addr == REG_CTRL)
      begin
         // only the control register changes here, the address is kept
         nxt_ctrl = reg_wdata & CTRL_MASK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_ff <= CTRL_RESET;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // address group, one register shared by all spaces
   always_comb
   begin
      nxt_addr = addr_ff;
      if (wr_ad && !data_fn)
      begin
         nxt_addr = reg_wdata;
      end
      else if (step)
      begin
         // memory uses addr_ff on this edge, so the new value counts afterwards
         // a step past the top of the word wraps to zero
         nxt_addr = addr_ff + ADDR_STEP;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         addr_ff <= ADDR_RESET;
      end
      else
      begin
         addr_ff <= nxt_addr;
      end
   end

   always_comb
   begin
      nxt_hold = hold_ff;
      // the answer stands one cycle only, idle cycles read zero
      nxt_rsel = SEL_ZERO;
      if (reg_re)
      begin
         if (reg_addr == REG_CTRL)
         begin
            nxt_hold = ctrl_ff;
            nxt_rsel = SEL_HOLD;
         end
         else if (rd_ad && !data_fn)
         begin
            nxt_hold = addr_ff;
            nxt_rsel = SEL_HOLD;
         end
         else if (mem_re)
         begin
            nxt_rsel = SEL_MEM;
         end
      end
   end

   // read group: held value and answer select
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hold_ff <= '0;
         rsel_ff <= SEL_ZERO;
      end
      else
      begin
         hold_ff <= nxt_hold;
         rsel_ff <= nxt_rsel;
      end
   end

   // one storage block serves all four spaces, the slot picks the quarter
   ierb_ext_mem #(
      .W  (DATA_W),
      .AW (EXT_AW)
   ) u_mem (
      .clk   (clk),
      .rst   (rst),
      .wr_en (mem_we),
      .rd_en (mem_re),
      .idx   (mem_idx),
      .wdata (reg_wdata),
      .rdata (mem_rdata)
   );

   // read data valid in the cycle after the read strobe only
   always_comb
   begin
      unique case (rsel_ff)
         SEL_HOLD: reg_rdata = hold_ff;
         SEL_MEM:  reg_rdata = mem_rdata;
         default:  reg_rdata = '0;
      endcase
   end
endmodule

/* File: testbench/ierb_station.sv */
// station model driving the register port of the block
module ierb_station
   import ierb_pkg::*;
(
   // clock
   input  wire logic              clk,
   // register port
   output logic [REG_ADDR_W-1:0]  reg_addr,
   output logic [DATA_W-1:0]      reg_wdata,
   output logic                   reg_we,
   output logic                   reg_re,
   input  wire logic [DATA_W-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {reg_addr, reg_wdata, reg_we, reg_re} = '0;
   // one strobe edge, then one idle cycle in which a read answer stands
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= w;
      reg_re    <= !w;
      @(posedge clk);
      reg_we    <= 1'b0;
      reg_re    <= 1'b0;
      #1;
      q = reg_rdata;
      @(posedge clk);
   endtask
endmodule

/* File: testbench/ierb_asserts.sv */
// assertions on the register port of the indirect access block
module ierb_checker
   import ierb_pkg::*;
#(
   parameter int EXT_AW = 8
)
(
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // register port
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0]     reg_wdata,
   input wire logic                  reg_we,
   input wire logic                  reg_re,
   input wire logic [DATA_W-1:0]     reg_rdata
);
   logic [15:0] ctl_ff;
   logic [15:0] adr_ff;
   logic [1:0]  fn;
   logic        ok;
   logic        ad;
   logic        inr;
   assign fn = ctl_ff[15:14];
   assign inr = ((adr_ff >> EXT_AW) == '0);
   assign ok = ctl_ff[4:0] inside {SPC_MAIN, SPC_PMA, SPC_VND3, SPC_VND7};
   assign ad = ok && reg_addr == REG_ADDR_DATA;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // shadow of control and address so each answer can be predicted
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl_ff <= CTRL_RESET;
         adr_ff <= ADDR_RESET;
      end
      else
      begin
         if (reg_we && reg_addr == REG_CTRL)
            ctl_ff <= reg_wdata & CTRL_MASK;
         if (ad && reg_we && fn == 2'h0)
            adr_ff <= reg_wdata;
         else if (ad && fn[1] && (reg_we || (reg_re && fn == 2'h2)))
            adr_ff <= adr_ff + ADDR_STEP;
      end
   end
   a_idle_zero: assert property (!reg_re |=> reg_rdata == '0)
      else $error("data outside answer");
   a_addr_echo: assert property (reg_re && ad && fn == 2'h0 |=> reg_rdata == $past(adr_ff))
      else $error("address readback");
   a_addr_load: assert property (reg_we && ad && fn == 2'h0
      ##2 reg_re && ad && fn == 2'h0 && $stable(ctl_ff)
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("address load");
   a_space_drop: assert property (reg_re && reg_addr == REG_ADDR_DATA && !ok |=> reg_rdata == '0)
      else $error("unsupported space");
   a_ctrl_back: assert property (reg_re && reg_addr == REG_CTRL |=> reg_rdata == $past(ctl_ff))
      else $error("control readback");
   a_data_keep: assert property (reg_we && ad && fn == 2'h1 && inr
      ##2 reg_re && ad && fn == 2'h1 && $stable(ctl_ff)
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("data write");
   a_rd_hold: assert property (reg_re && ad && fn == 2'h3
      ##2 reg_re && ad && fn == 2'h3 && $stable(ctl_ff)
      |=> reg_rdata == $past(reg_rdata, 2)) else $error("read stepped");
   a_bad_index: assert property (reg_re && reg_addr > REG_ADDR_DATA |=> reg_rdata == '0)
      else $error("unmapped read");
   c_step_rd: cover property (reg_re && ad && fn == 2'h2);
   c_step_wr: cover property (reg_we && ad && fn == 2'h3);
   c_drop: cover property (reg_we && reg_addr == REG_ADDR_DATA && !ok);
endmodule

bind ierb_indirect_access ierb_checker #(.EXT_AW(EXT_AW)) i_ierb_checker (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata));

/* File: testbench/tb.sv */
// self-checking bench for the indirect extended register access block
module tb;
   import ierb_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_we;
   logic        reg_re;
   logic [15:0] reg_rdata;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [4:0]  spc [4] = '{SPC_MAIN, SPC_PMA, SPC_VND3, SPC_VND7};
   ierb_indirect_access i_ierb_indirect_access (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
   ierb_station i_ierb_station (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wc(input logic [15:0] d);
      logic [15:0] q;
      i_ierb_station.acc(1'b1, REG_CTRL, d, q);
   endtask
   task automatic wd(input logic [15:0] d);
      logic [15:0] q;
      i_ierb_station.acc(1'b1, REG_ADDR_DATA, d, q);
   endtask
   // the station takes the data in the one cycle after the strobe
   task automatic rd(input logic [15:0] exp, input logic [4:0] a = REG_ADDR_DATA);
      logic [15:0] q;
      i_ierb_station.acc(1'b0, a, 16'h0000, q);
      chk("reg_rdata", q, exp);
   endtask
   initial forever #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(CTRL_RESET, REG_CTRL);
      rd(16'h0000);
      foreach (spc[i])
      begin
         wc({11'h000, spc[i]});
         wd(16'h00ff);
         wd(16'h0005);
         rd(16'h0005);
         wc({11'h200, spc[i]});
         wd(16'h1111);
         wd({11'h528, spc[i]});
         rd({11'h528, spc[i]});
      end
      foreach (spc[i])
      begin
         wc({11'h200, spc[i]});
         rd({11'h528, spc[i]});
         rd({11'h528, spc[i]});
      end
      wc(16'h001f);
      wd(16'h0008);
      wc(16'h801f);
      for (int k = 0; k < 3; k++)
         wd(16'hd000 + 16'(k));
      wc(16'h001f);
      rd(16'h000b);
      wd(16'h0008);
      wc(16'h801f);
      rd(16'hd000);
      rd(16'hd001);
      wc(16'h001f);
      rd(16'h000a);
      wc(16'hc01f);
      rd(16'hd002);
      rd(16'hd002);
      wd(16'h1234);
      wc(16'h001f);
      rd(16'h000b);
      wc(16'h4002);
      wd(16'hffff);
      rd(16'h0000);
      wc(16'hffff);
      rd(16'hc01f, REG_CTRL);
      rd(16'h0000, 5'h10);
      wc(16'h001f);
      rd(16'h000b);
      // an address past the storage depth drops data but still steps
      wd(16'h0100);
      wc(16'h401f);
      wd(16'hbeef);
      rd(16'h0000);
      wc(16'h801f);
      rd(16'h0000);
      wc(16'h001f);
      rd(16'h0101);
      print_verdict();
   end
endmodule
